// ==== rtl/omc_pkg.sv ====
// operating mode controller package: types, offsets, reset values
// assumes a 32-bit apb master and pins synchronised inside the block
package omc_pkg;

  typedef enum logic [2:0] {
    OMC_NOT_POWERED,
    OMC_POWER_OFF,
    OMC_IDLE,
    OMC_ACTIVE,
    OMC_CONNECTED
  } omc_mode_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } omc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } omc_apb_rsp_t;

  // register byte offsets
  localparam logic [7:0] OMC_OFS_CTRL = 8'h00;
  localparam logic [7:0] OMC_OFS_STATUS = 8'h04;
  localparam logic [7:0] OMC_OFS_ALARM = 8'h08;
  localparam logic [7:0] OMC_OFS_WAKE = 8'h0c;

  // control fields
  localparam int OMC_CTRL_PS_LSB = 0;
  localparam int OMC_CTRL_FLOW_OFF = 2;
  localparam logic [1:0] OMC_PS_RST = 2'h0;
  localparam logic [1:0] OMC_PS_OFF = 2'h0;
  localparam logic [1:0] OMC_PS_UART_TIMER = 2'h1;
  localparam logic [1:0] OMC_PS_RTS = 2'h2;

  // wake cause bits
  localparam int OMC_WAKE_W = 6;
  localparam int OMC_WK_PAGING = 0;
  localparam int OMC_WK_TIMER = 1;
  localparam int OMC_WK_ALARM = 2;
  localparam int OMC_WK_RX = 3;
  localparam int OMC_WK_RTS = 4;
  localparam int OMC_WK_GNSS = 5;

  // synchronised pin indices
  localparam int OMC_PIN_W = 7;
  localparam int OMC_PIN_SUPPLY = 0;
  localparam int OMC_PIN_PON_REQ_N = 1;
  localparam int OMC_PIN_RX = 2;
  localparam int OMC_PIN_RTS_N = 3;
  localparam int OMC_PIN_GNSS = 4;
  localparam int OMC_PIN_EXT_CLK = 5;
  localparam int OMC_PIN_OFF_EVT = 6;
  // idle levels: supply absent, request released, line idle, rts off
  localparam logic [6:0] OMC_PIN_RST = 7'h0e;

  // cycle counts
  localparam int OMC_ACTIVE_HOLD_CYC = 64;
  localparam int OMC_UART_WAKE_CYC = 25000;

endpackage

// ==== rtl/omc_operating_mode_controller.sv ====
// operating mode controller: not-powered, power-off, idle, active, connected
// assumes call and paging pulses and the rtc alarm come from logic on the
// core clock; supply, request, uart and gnss lines are asynchronous pins
`timescale 1ns/1ps

// Function
// - supply loss forces not-powered mode
// - not-powered ignores power-on request and alarm
// - supply applied goes straight to active
// - power-off event in active enters power-off
// - power-off wakes on request low or alarm
// - supply loss in power-off gives not-powered
// - power-off: interfaces closed, only rtc runs
// - idle clocks core from slow reference
// - active and connected use fast reference
// - power saving resets disabled, set by command
// - power saving lets active drop to idle
// - paging instant wakes idle to active
// - setting one wakes periodically for uart
// - armed rtc alarm wakes idle
// - uart receive data wakes idle
// - rts on wakes when flow off, setting two
// - gnss data ready pin wakes idle
// - cts shows uart enabled or disabled
// - idle refuses application interface traffic
// - no idle without a slow clock source
// - call start moves active to connected
// - call end returns connected to active
// - power saving off keeps mode active
module omc_operating_mode_controller
  import omc_pkg::*;
#(
  parameter int HAS_SLOW_OSC = 1,
  parameter int ACTIVE_HOLD = OMC_ACTIVE_HOLD_CYC,
  parameter int UART_WAKE_PERIOD = OMC_UART_WAKE_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire omc_apb_req_t i_apb,
  output omc_apb_rsp_t o_apb,
  input wire logic i_supply_present,
  input wire logic i_power_on_request_n,
  input wire logic i_uart_rx,
  input wire logic i_rts_n,
  input wire logic i_positioning_data_ready_pin,
  input wire logic i_ext_slow_clock_in_valid,
  input wire logic i_power_off_event,
  input wire logic i_rtc_alarm,
  input wire logic i_paging_due,
  input wire logic i_call_start,
  input wire logic i_call_end,
  input wire logic i_activity_busy,
  output omc_mode_t o_mode,
  output logic o_core_clk_fast,
  output logic o_slow_clk_from_ext,
  output logic o_iface_enable,
  output logic o_rtc_run,
  output logic o_cts_n
);

  generate
    if (HAS_SLOW_OSC < 0 || HAS_SLOW_OSC > 1) begin : g_chk_osc
      $error("HAS_SLOW_OSC must be 0 or 1");
    end
    if (ACTIVE_HOLD < 1 || ACTIVE_HOLD > 65535) begin : g_chk_hold
      $error("ACTIVE_HOLD out of range");
    end
    if (UART_WAKE_PERIOD < 2 || UART_WAKE_PERIOD > 16777215) begin : g_chk_per
      $error("UART_WAKE_PERIOD out of range");
    end
  endgenerate

  localparam logic [15:0] HOLD_LOAD = 16'(ACTIVE_HOLD);
  localparam logic [23:0] PERIOD_END = 24'(UART_WAKE_PERIOD - 1);

  logic [OMC_PIN_W-1:0] pin_raw;
  logic [OMC_PIN_W-1:0] pin_s1;
  logic [OMC_PIN_W-1:0] pin_s2;
  logic [OMC_PIN_W-1:0] pin_s3;
  logic [OMC_PIN_W-1:0] pin;
  logic [OMC_PIN_W-1:0] pin_d;

  omc_mode_t mode;
  omc_mode_t next_mode;
  logic [1:0] ps_setting;
  logic flow_off;
  logic alarm_armed;
  logic [OMC_WAKE_W-1:0] wake_cause;
  logic [OMC_WAKE_W-1:0] wake_now;
  logic [15:0] hold_cnt;
  logic [23:0] uart_tmr;
  logic timer_hit;
  logic slow_ok;
  logic ps_enabled;
  logic idle_ok;
  logic wake_any;
  logic alarm_hit;
  logic off_evt;
  logic apb_setup;
  logic apb_write;
  logic [31:0] rd_data;
  logic rd_err;
  logic up_next;
  logic [31:0] prdata_q;
  logic pslverr_q;

  assign pin_raw[OMC_PIN_SUPPLY] = i_supply_present;
  assign pin_raw[OMC_PIN_PON_REQ_N] = i_power_on_request_n;
  assign pin_raw[OMC_PIN_RX] = i_uart_rx;
  assign pin_raw[OMC_PIN_RTS_N] = i_rts_n;
  assign pin_raw[OMC_PIN_GNSS] = i_positioning_data_ready_pin;
  assign pin_raw[OMC_PIN_EXT_CLK] = i_ext_slow_clock_in_valid;
  assign pin_raw[OMC_PIN_OFF_EVT] = i_power_off_event;

  // three stages; a level is taken only once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < OMC_PIN_W; gi++) begin : g_sync
      always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          pin_s1[gi] <= OMC_PIN_RST[gi];
          pin_s2[gi] <= OMC_PIN_RST[gi];
          pin_s3[gi] <= OMC_PIN_RST[gi];
          pin[gi] <= OMC_PIN_RST[gi];
          pin_d[gi] <= OMC_PIN_RST[gi];
        end else begin
          pin_s1[gi] <= pin_raw[gi];
          pin_s2[gi] <= pin_s1[gi];
          pin_s3[gi] <= pin_s2[gi];
          pin_d[gi] <= pin[gi];
          if (pin_s2[gi] == pin_s3[gi]) begin
            pin[gi] <= pin_s3[gi];
          end
        end
      end
    end
  endgenerate

  assign slow_ok = (HAS_SLOW_OSC == 1) || pin[OMC_PIN_EXT_CLK];
  assign ps_enabled = (ps_setting != OMC_PS_OFF);
  assign alarm_hit = i_rtc_alarm && alarm_armed;
  assign off_evt = pin[OMC_PIN_OFF_EVT] && !pin_d[OMC_PIN_OFF_EVT];
  assign timer_hit = (ps_setting == OMC_PS_UART_TIMER) && (uart_tmr == PERIOD_END);

  assign wake_now[OMC_WK_PAGING] = i_paging_due;
  assign wake_now[OMC_WK_TIMER] = timer_hit;
  assign wake_now[OMC_WK_ALARM] = alarm_hit;
  assign wake_now[OMC_WK_RX] = pin_d[OMC_PIN_RX] && !pin[OMC_PIN_RX];
  assign wake_now[OMC_WK_RTS] = flow_off && (ps_setting == OMC_PS_RTS)
                                && !pin[OMC_PIN_RTS_N];
  assign wake_now[OMC_WK_GNSS] = pin[OMC_PIN_GNSS];

  assign wake_any = |wake_now;

  // idle only when quiet; never with saving off
  assign idle_ok = ps_enabled && slow_ok && !i_activity_busy
                   && (hold_cnt == 16'h0000) && !wake_any;

  always_comb begin
    next_mode = mode;
    if (!pin[OMC_PIN_SUPPLY]) begin
      next_mode = OMC_NOT_POWERED;
    end else begin
      case (mode)
        OMC_NOT_POWERED: begin
          next_mode = OMC_ACTIVE;
        end
        OMC_POWER_OFF: begin
          if (!pin[OMC_PIN_PON_REQ_N] || alarm_hit) begin
            next_mode = OMC_ACTIVE;
          end
        end
        OMC_IDLE: begin
          if (wake_any) begin
            next_mode = OMC_ACTIVE;
          end
        end
        OMC_ACTIVE: begin
          if (off_evt) begin
            next_mode = OMC_POWER_OFF;
          end else if (i_call_start) begin
            next_mode = OMC_CONNECTED;
          end else if (idle_ok) begin
            next_mode = OMC_IDLE;
          end
        end
        OMC_CONNECTED: begin
          if (i_call_end) begin
            next_mode = OMC_ACTIVE;
          end
        end
        default: begin
          next_mode = OMC_NOT_POWERED;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mode <= OMC_NOT_POWERED;
    end else begin
      mode <= next_mode;
    end
  end

  // keeps a woken core awake long enough to do its work before idling again
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hold_cnt <= 16'h0000;
    end else if (next_mode == OMC_ACTIVE && mode != OMC_ACTIVE) begin
      hold_cnt <= HOLD_LOAD;
    end else if (mode == OMC_ACTIVE && hold_cnt != 16'h0000) begin
      hold_cnt <= hold_cnt - 16'h0001;
    end
  end

  // idle period counter, cleared whenever idle is left
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      uart_tmr <= 24'h000000;
    end else if (mode != OMC_IDLE || timer_hit) begin
      uart_tmr <= 24'h000000;
    end else begin
      uart_tmr <= uart_tmr + 24'h000001;
    end
  end

  assign up_next = (next_mode == OMC_ACTIVE) || (next_mode == OMC_CONNECTED);

  // outputs other than o_slow_clk_from_ext follow next_mode so they change on the same edge as the mode
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_mode <= OMC_NOT_POWERED;
    end else begin
      o_mode <= next_mode;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_core_clk_fast <= 1'b0;
    end else begin
      o_core_clk_fast <= up_next;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_slow_clk_from_ext <= 1'b0;
    end else begin
      o_slow_clk_from_ext <= (HAS_SLOW_OSC == 0);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_iface_enable <= 1'b0;
    end else begin
      o_iface_enable <= up_next;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rtc_run <= 1'b0;
    end else begin
      o_rtc_run <= (next_mode != OMC_NOT_POWERED);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_cts_n <= 1'b1;
    end else begin
      o_cts_n <= !up_next;
    end
  end

  // apb slave: zero wait states, read data captured in the setup cycle
  assign apb_setup = i_apb.psel && !i_apb.penable;
  assign apb_write = i_apb.psel && i_apb.penable && i_apb.pwrite;

  // saving setting only through the control write
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ps_setting <= OMC_PS_RST;
      flow_off <= 1'b0;
    end else if (apb_write && i_apb.paddr == OMC_OFS_CTRL) begin
      ps_setting <= i_apb.pwdata[OMC_CTRL_PS_LSB +: 2];
      flow_off <= i_apb.pwdata[OMC_CTRL_FLOW_OFF];
    end
  end

  // alarm armed by command, consumed when it fires in idle or power-off
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      alarm_armed <= 1'b0;
    end else if (apb_write && i_apb.paddr == OMC_OFS_ALARM) begin
      alarm_armed <= i_apb.pwdata[0];
    end else if (alarm_hit && (mode == OMC_IDLE || mode == OMC_POWER_OFF)) begin
      alarm_armed <= 1'b0;
    end
  end

  // sticky wake causes, write one to clear; a new wake beats the clear
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wake_cause <= '0;
    end else begin
      for (int k = 0; k < OMC_WAKE_W; k++) begin
        if (mode == OMC_IDLE && wake_now[k]) begin
          wake_cause[k] <= 1'b1;
        end else if (apb_write && i_apb.paddr == OMC_OFS_WAKE && i_apb.pwdata[k]) begin
          wake_cause[k] <= 1'b0;
        end
      end
    end
  end

  always_comb begin
    rd_data = 32'h00000000;
    rd_err = 1'b0;
    case (i_apb.paddr)
      OMC_OFS_CTRL: begin
        rd_data[OMC_CTRL_PS_LSB +: 2] = ps_setting;
        rd_data[OMC_CTRL_FLOW_OFF] = flow_off;
      end
      OMC_OFS_STATUS: begin
        rd_data[2:0] = mode;
        rd_data[3] = o_core_clk_fast;
        rd_data[4] = !o_cts_n;
        rd_data[5] = o_iface_enable;
        rd_data[6] = slow_ok;
        rd_data[7] = pin[OMC_PIN_SUPPLY];
      end
      OMC_OFS_ALARM: begin
        rd_data[0] = alarm_armed;
      end
      OMC_OFS_WAKE: begin
        rd_data[OMC_WAKE_W-1:0] = wake_cause;
      end
      default: begin
        rd_err = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else if (apb_setup) begin
      prdata_q <= i_apb.pwrite ? 32'h00000000 : rd_data;
      pslverr_q <= rd_err;
    end
  end

  // no wait states: every access completes in its first access cycle
  assign o_apb = '{prdata: prdata_q, pready: 1'b1, pslverr: pslverr_q};

endmodule

// ==== tb/omc_chk_sva.sv ====
// checker on the mode outputs of the controller
// assumes binding onto the controller top ports
`timescale 1ns/1ps
module omc_chk
  import omc_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_call_start,
  input wire logic i_call_end,
  input wire logic i_activity_busy,
  input wire omc_mode_t o_mode,
  input wire logic o_core_clk_fast,
  input wire logic o_iface_enable,
  input wire logic o_rtc_run,
  input wire logic o_cts_n
);
  logic up;
  assign up = o_mode inside {OMC_ACTIVE, OMC_CONNECTED};
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_b);
  cts_level_a: assert property (o_cts_n == !up) else $error("cts level wrong");
  fast_ref_a: assert property (o_core_clk_fast == up) else $error("clock ref wrong");
  iface_gate_a: assert property (o_iface_enable == up) else $error("iface wrong");
  rtc_run_a: assert property (o_rtc_run == (o_mode != OMC_NOT_POWERED))
    else $error("rtc run wrong");
  power_up_a: assert property ($past(o_mode) == OMC_NOT_POWERED && o_mode != OMC_NOT_POWERED
    |-> o_mode == OMC_ACTIVE) else $error("bad power up");
  call_start_a: assert property (o_mode == OMC_CONNECTED && $past(o_mode) != OMC_CONNECTED
    |-> $past(o_mode) == OMC_ACTIVE && $past(i_call_start)) else $error("bad call start");
  call_end_a: assert property ($past(o_mode) == OMC_CONNECTED && o_mode == OMC_ACTIVE
    |-> $past(i_call_end)) else $error("bad call end");
  idle_entry_a: assert property (o_mode == OMC_IDLE && $past(o_mode) != OMC_IDLE
    |-> $past(o_mode) == OMC_ACTIVE && !$past(i_activity_busy)) else $error("bad idle");
  poff_entry_a: assert property (o_mode == OMC_POWER_OFF && $past(o_mode) != OMC_POWER_OFF
    |-> $past(o_mode) == OMC_ACTIVE) else $error("bad power off");
  call_hold_a: assert property (o_mode == OMC_CONNECTED && !i_call_end
    |=> o_mode != OMC_ACTIVE) else $error("call dropped");
endmodule

// ==== tb/omc_dte.sv ====
// host side model: uart receive data and rts
// assumes the core clock; line idles high, rts pulled up
`timescale 1ns/1ps
module omc_dte (
  input wire logic i_clk,
  input wire logic i_send,
  input wire logic i_rts_req,
  output logic o_rx,
  output logic o_rts_n
);
  logic [9:0] frm = '1;
  logic [1:0] div = '0;
  // four clocks a bit so the pin filter sees each bit
  always @(posedge i_clk) begin
    div <= div + 2'h1;
    if (i_send)
      frm <= {1'b1, 8'h5a, 1'b0};
    else if (div == 2'h3)
      frm <= {1'b1, frm[9:1]};
  end
  assign o_rx = frm[0];
  assign o_rts_n = !i_rts_req;
endmodule

// ==== tb/tb.sv ====
// bench for the operating mode controller
// assumes the default hold count and a short wake count set below
`timescale 1ns/1ps
module tb;
  import omc_pkg::*;
  logic clk, rst_b, sup, pon_n, gnss, ext_ok, off_evt, alarm, paging, cs, ce, busy;
  logic send, rts_req, rx, rts_n, fast, from_ext, ifen, rtc, cts_n, err;
  logic [31:0] rd;
  omc_apb_req_t apb;
  omc_apb_rsp_t rsp;
  omc_mode_t mode, last;
  omc_mode_t exp_q[$];
  int error_cnt, check_count;
  omc_operating_mode_controller #(.ACTIVE_HOLD(64), .UART_WAKE_PERIOD(16)) i_dut (
    .i_core_clk(clk), .i_rst_b(rst_b), .i_apb(apb), .o_apb(rsp),
    .i_supply_present(sup), .i_power_on_request_n(pon_n), .i_uart_rx(rx),
    .i_rts_n(rts_n), .i_positioning_data_ready_pin(gnss),
    .i_ext_slow_clock_in_valid(ext_ok), .i_power_off_event(off_evt),
    .i_rtc_alarm(alarm), .i_paging_due(paging), .i_call_start(cs), .i_call_end(ce),
    .i_activity_busy(busy), .o_mode(mode), .o_core_clk_fast(fast),
    .o_slow_clk_from_ext(from_ext), .o_iface_enable(ifen), .o_rtc_run(rtc),
    .o_cts_n(cts_n));
  omc_dte i_dte (.i_clk(clk), .i_send(send), .i_rts_req(rts_req), .o_rx(rx),
    .o_rts_n(rts_n));
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic bus(logic wr, logic [7:0] a, logic [31:0] d);
    apb <= '{1'b1, 1'b0, wr, a, d};
    @(posedge clk);
    apb.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    apb <= '0;
    @(posedge clk);
  endtask
  // note the mode expected next, then wait for it
  task automatic go(omc_mode_t m);
    exp_q.push_back(m);
    repeat (400) if (mode !== m) @(posedge clk);
    @(posedge clk);
  endtask
  task automatic conclude();
    chk("queue", 0, exp_q.size());
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // any unnoted mode change fails against the old mode
  always @(posedge clk) begin
    if (rst_b && mode !== last)
      chk("mode", exp_q.size() ? exp_q.pop_front() : last, mode);
    last <= mode;
  end
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    conclude();
  end
  initial begin
    {rst_b, sup, gnss, off_evt, alarm, paging, cs, ce, busy, send, rts_req} = '0;
    pon_n = 1;
    ext_ok = 1;
    apb = '0;
    void'($urandom(17094));
    repeat (10) @(posedge clk);
    rst_b <= 1;
    @(posedge clk);
    bus(0, OMC_OFS_CTRL, 0);
    chk("ctrl", 0, rd);
    chk("from_ext", 0, from_ext);
    chk("cts_n", 1, cts_n);
    bus(1, 8'h10, $urandom);
    chk("slverr", 1, err);
    bus(1, OMC_OFS_ALARM, 1);
    pon_n <= 0;
    alarm <= 1;
    repeat (12) @(posedge clk);
    pon_n <= 1;
    alarm <= 0;
    repeat (8) @(posedge clk);
    sup <= 1;
    go(OMC_ACTIVE);
    off_evt <= 1;
    go(OMC_POWER_OFF);
    off_evt <= 0;
    pon_n <= 0;
    go(OMC_ACTIVE);
    pon_n <= 1;
    cs <= 1;
    @(posedge clk);
    cs <= 0;
    go(OMC_CONNECTED);
    paging <= 1;
    @(posedge clk);
    paging <= 0;
    repeat (8) @(posedge clk);
    ce <= 1;
    @(posedge clk);
    ce <= 0;
    go(OMC_ACTIVE);
    busy <= 1;
    bus(1, OMC_OFS_ALARM, 1);
    bus(1, OMC_OFS_CTRL, ($urandom & 32'hffff_fff8) | 32'h3);
    repeat (30) @(posedge clk);
    busy <= 0;
    for (int k = 0; k < 4; k++) begin
      go(OMC_IDLE);
      case (k)
        0: paging <= 1;
        1: send <= 1;
        2: gnss <= 1;
        default: alarm <= 1;
      endcase
      @(posedge clk);
      {paging, send, alarm} <= '0;
      go(OMC_ACTIVE);
      gnss <= 0;
    end
    bus(1, OMC_OFS_CTRL, 32'h6);
    go(OMC_IDLE);
    rts_req <= 1;
    go(OMC_ACTIVE);
    rts_req <= 0;
    bus(1, OMC_OFS_CTRL, 32'h1);
    go(OMC_IDLE);
    go(OMC_ACTIVE);
    bus(1, OMC_OFS_CTRL, 32'h0);
    repeat (150) @(posedge clk);
    sup <= 0;
    go(OMC_NOT_POWERED);
    conclude();
  end
endmodule
bind omc_operating_mode_controller omc_chk i_chk (.i_core_clk, .i_rst_b, .i_call_start,
  .i_call_end, .i_activity_busy, .o_mode, .o_core_clk_fast, .o_iface_enable, .o_rtc_run,
  .o_cts_n);
